// ---- src/link_mode_pkg.sv ----
// Shared mode encodings, constants and the mode-combination function.
package link_mode_pkg;

   typedef enum logic [2:0] {
      MODE_AUTO,
      MODE_FULL_VIDEO,
      MODE_EXT_REACH,
      MODE_SERIAL_ONLY,
      MODE_SERIAL_NET
   } mode_t;

   localparam mode_t       RESET_MODE   = MODE_SERIAL_ONLY;
   localparam int unsigned CLK_HZ       = 125_000_000;
   localparam int unsigned SERIAL_BAUD  = 9600;
   localparam int unsigned BAUD_DIV_W   = 16;
   localparam logic [BAUD_DIV_W-1:0] BAUD_DIV =
      BAUD_DIV_W'(CLK_HZ / SERIAL_BAUD);

   // Both ends evaluate the same function on the same pair of selections;
   // the initiating end sends the result itself as its proposal, which the other end adopts.
   function automatic mode_t resolve(input logic  basic,
                                     input mode_t tx_sel,
                                     input mode_t rx_sel,
                                     input logic  video_ok);
      mode_t m;
      m = MODE_FULL_VIDEO;
      if (basic) begin
         if (rx_sel == MODE_SERIAL_ONLY || tx_sel == MODE_SERIAL_ONLY ||
             tx_sel == MODE_SERIAL_NET || tx_sel == MODE_EXT_REACH) begin
            m = MODE_SERIAL_ONLY; // [RULE8]
         end else if (tx_sel == MODE_AUTO && rx_sel == MODE_AUTO) begin
            m = video_ok ? MODE_FULL_VIDEO : MODE_SERIAL_ONLY; // [RULE9]
         end
      end else begin
         if (tx_sel == MODE_SERIAL_ONLY || rx_sel == MODE_SERIAL_ONLY) begin
            m = MODE_SERIAL_ONLY; // [RULE5]
         end else if (tx_sel == MODE_SERIAL_NET ||
                      rx_sel == MODE_SERIAL_NET) begin
            m = MODE_SERIAL_NET; // [RULE5]
         end else if (tx_sel == MODE_AUTO && rx_sel == MODE_AUTO) begin
            m = video_ok ? MODE_FULL_VIDEO : MODE_SERIAL_NET; // [RULE7]
         end else if (tx_sel == MODE_EXT_REACH ||
                      rx_sel == MODE_EXT_REACH) begin
            m = MODE_EXT_REACH; // [RULE6]
         end
      end
      return m;
   endfunction : resolve

endpackage : link_mode_pkg

// ---- src/twisted_pair_link_if.sv ----
// Mode negotiation wires between the transmit end and the receive end.
interface twisted_pair_link_if;
   link_mode_pkg::mode_t tx_sel;
   logic                 tx_video_ok;
   logic                 tx_req;
   link_mode_pkg::mode_t tx_prop;
   logic                 tx_ack;
   link_mode_pkg::mode_t rx_sel;
   logic                 rx_req;
   link_mode_pkg::mode_t rx_prop;
   logic                 rx_ack;

   modport tx_end (output tx_sel, tx_video_ok, tx_req, tx_prop, tx_ack,
                   input  rx_sel, rx_req, rx_prop, rx_ack);
   modport rx_end (output rx_sel, rx_req, rx_prop, rx_ack,
                   input  tx_sel, tx_video_ok, tx_req, tx_prop, tx_ack);
endinterface : twisted_pair_link_if

// ---- src/link_mode_tx.sv ----
// Transmit (source) end of the link mode resolver.
// Function
// RULE1: Five selectable modes including automatic.
// RULE2: Serial-only mode carries only 9600 baud serial.
// RULE3: Serial-net mode carries serial plus network, no video.
// RULE4: Final mode uses both ends' selections.
// RULE5: Full variant: serial-only, then serial-net dominate.
// RULE6: Full variant: extended reach wins, else full video.
// RULE7: Full both-auto: video present full, else serial-net.
// RULE8: Basic variant: three receive choices, serial-only table.
// RULE9: Basic both-auto: video present full, else serial-only.
// RULE10: Automatic end decides from sensed valid video.
// RULE11: Both automatic: source initiates, sink responds.
// RULE12: Manual end initiates, automatic end follows.
// RULE13: Resolved mode registered, changes on negotiation only.
module link_mode_tx #(
   parameter bit BASIC = 1'b0
) (
   input  wire logic                            CORE_CLK,
   input  wire logic                            RST_N,
   twisted_pair_link_if.tx_end                  LINK,
   input  wire link_mode_pkg::mode_t            SEL_MODE,
   input  wire logic                            VIDEO_VALID,
   output link_mode_pkg::mode_t                 MODE,
   output logic                                 VIDEO_EN,
   output logic                                 NET_EN,
   output logic                                 SERIAL_EN,
   output logic [link_mode_pkg::BAUD_DIV_W-1:0] BAUD_DIV,
   output logic                                 BUSY
);

   typedef enum logic [1:0] {ST_IDLE, ST_PROPOSE, ST_RELEASE} state_t;

   state_t               state_q;
   link_mode_pkg::mode_t mode_q;
   link_mode_pkg::mode_t prop_q;
   link_mode_pkg::mode_t target;
   logic                 ack_q;
   logic                 initiator;

   assign LINK.tx_sel      = SEL_MODE;                               // [RULE1]
   assign LINK.tx_video_ok = VIDEO_VALID;                            // [RULE10]
   assign LINK.tx_req      = (state_q == ST_PROPOSE);
   assign LINK.tx_prop     = prop_q;
   assign LINK.tx_ack      = ack_q;

   assign target = link_mode_pkg::resolve(BASIC, SEL_MODE, LINK.rx_sel,
                                          VIDEO_VALID);      // [RULE4]

   // The receive end leads only when it alone is manual; with both manual
   // the source leads, which keeps exactly one initiator at any time.
   assign initiator = !(SEL_MODE == link_mode_pkg::MODE_AUTO &&
                        LINK.rx_sel != link_mode_pkg::MODE_AUTO); // [RULE11]

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         prop_q  <= link_mode_pkg::RESET_MODE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               // A stale request from the peer is answered first, so two
               // proposals never stand on the link at the same time.
               if (initiator && target != mode_q && !ack_q &&
                   !LINK.rx_req) begin
                  prop_q  <= target;                                 // [RULE11]
                  state_q <= ST_PROPOSE;
               end
            end
            ST_PROPOSE: begin
               if (LINK.rx_ack) begin
                  state_q <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               if (!LINK.rx_ack) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Following the partner: acknowledge its proposal and hold the ack until
   // the request drops, so one proposal is taken exactly once.
   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack_q <= 1'b0;
      end else if (LINK.rx_req && !ack_q && state_q == ST_IDLE) begin
         ack_q <= 1'b1;                                              // [RULE12]
      end else if (!LINK.rx_req) begin
         ack_q <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_q <= link_mode_pkg::RESET_MODE;
      end else if (state_q == ST_PROPOSE && LINK.rx_ack) begin
         mode_q <= prop_q;                                           // [RULE13]
      end else if (LINK.rx_req && !ack_q && state_q == ST_IDLE) begin
         mode_q <= LINK.rx_prop;                                     // [RULE12]
      end
   end

   assign MODE      = mode_q;
   assign SERIAL_EN = 1'b1;                                      // [RULE2]
   assign NET_EN    = (mode_q != link_mode_pkg::MODE_SERIAL_ONLY); // [RULE3]
   assign VIDEO_EN  = (mode_q == link_mode_pkg::MODE_FULL_VIDEO ||
                       mode_q == link_mode_pkg::MODE_EXT_REACH);  // [RULE3]
   assign BAUD_DIV  = link_mode_pkg::BAUD_DIV;                   // [RULE2]
   assign BUSY      = (state_q != ST_IDLE) || ack_q;

endmodule : link_mode_tx

// ---- src/link_mode_rx.sv ----
// Receive (sink) end of the link mode resolver.
module link_mode_rx #(
   parameter bit BASIC = 1'b0
) (
   input  wire logic                            CORE_CLK,
   input  wire logic                            RST_N,
   twisted_pair_link_if.rx_end                  LINK,
   input  wire link_mode_pkg::mode_t            SEL_MODE,
   output link_mode_pkg::mode_t                 MODE,
   output logic                                 VIDEO_EN,
   output logic                                 NET_EN,
   output logic                                 SERIAL_EN,
   output logic [link_mode_pkg::BAUD_DIV_W-1:0] BAUD_DIV,
   output logic                                 BUSY
);

   typedef enum logic [1:0] {ST_IDLE, ST_PROPOSE, ST_RELEASE} state_t;

   state_t               state_q;
   link_mode_pkg::mode_t mode_q;
   link_mode_pkg::mode_t prop_q;
   link_mode_pkg::mode_t sel;
   link_mode_pkg::mode_t target;
   logic                 ack_q;
   logic                 initiator;

   // The basic variant has no extended reach or serial-net choice here;
   // such a selection is treated as automatic.
   always_comb begin
      sel = SEL_MODE;
      if (BASIC && (SEL_MODE == link_mode_pkg::MODE_EXT_REACH ||
                    SEL_MODE == link_mode_pkg::MODE_SERIAL_NET)) begin
         sel = link_mode_pkg::MODE_AUTO;                             // [RULE8]
      end
   end

   assign LINK.rx_sel  = sel;                                        // [RULE1]
   assign LINK.rx_req  = (state_q == ST_PROPOSE);
   assign LINK.rx_prop = prop_q;
   assign LINK.rx_ack  = ack_q;

   assign target = link_mode_pkg::resolve(BASIC, LINK.tx_sel, sel,
                                          LINK.tx_video_ok); // [RULE4]

   assign initiator = (sel != link_mode_pkg::MODE_AUTO &&
                       LINK.tx_sel == link_mode_pkg::MODE_AUTO); // [RULE12]

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_q <= ST_IDLE;
         prop_q  <= link_mode_pkg::RESET_MODE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (initiator && target != mode_q && !ack_q &&
                   !LINK.tx_req) begin
                  prop_q  <= target;                                 // [RULE12]
                  state_q <= ST_PROPOSE;
               end
            end
            ST_PROPOSE: begin
               if (LINK.tx_ack) begin
                  state_q <= ST_RELEASE;
               end
            end
            ST_RELEASE: begin
               if (!LINK.tx_ack) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack_q <= 1'b0;
      end else if (LINK.tx_req && !ack_q && state_q == ST_IDLE) begin
         ack_q <= 1'b1;                                              // [RULE11]
      end else if (!LINK.tx_req) begin
         ack_q <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         mode_q <= link_mode_pkg::RESET_MODE;
      end else if (state_q == ST_PROPOSE && LINK.tx_ack) begin
         mode_q <= prop_q;                                           // [RULE13]
      end else if (LINK.tx_req && !ack_q && state_q == ST_IDLE) begin
         mode_q <= LINK.tx_prop;                                     // [RULE11]
      end
   end

   assign MODE      = mode_q;
   assign SERIAL_EN = 1'b1;                                      // [RULE2]
   assign NET_EN    = (mode_q != link_mode_pkg::MODE_SERIAL_ONLY); // [RULE3]
   assign VIDEO_EN  = (mode_q == link_mode_pkg::MODE_FULL_VIDEO ||
                       mode_q == link_mode_pkg::MODE_EXT_REACH);  // [RULE3]
   assign BAUD_DIV  = link_mode_pkg::BAUD_DIV;                   // [RULE2]
   assign BUSY      = (state_q != ST_IDLE) || ack_q;

endmodule : link_mode_rx

// ---- verif/link_mode_sva.sv ----
// Checker for the mode negotiation handshake between the two link ends.
module link_mode_sva (
   input wire logic                 CORE_CLK,
   input wire logic                 RST_N,
   input wire link_mode_pkg::mode_t tx_sel,
   input wire logic                 tx_video_ok,
   input wire logic                 tx_req,
   input wire link_mode_pkg::mode_t tx_prop,
   input wire logic                 tx_ack,
   input wire link_mode_pkg::mode_t rx_sel,
   input wire logic                 rx_req,
   input wire link_mode_pkg::mode_t rx_prop,
   input wire logic                 rx_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic tx_auto = tx_sel == link_mode_pkg::MODE_AUTO;
   wire logic rx_auto = rx_sel == link_mode_pkg::MODE_AUTO;
   wire logic any_so  = tx_sel == link_mode_pkg::MODE_SERIAL_ONLY ||
                        rx_sel == link_mode_pkg::MODE_SERIAL_ONLY;
   default clocking cb @(posedge CORE_CLK);
   endclocking
   default disable iff (!RST_N);
   sequence s_tx_take;
      $rose(tx_req);
   endsequence
   sequence s_tx_done;
      tx_req && rx_ack;
   endsequence
   AST_TX_REQ_HOLD: assert property (
      tx_req && !rx_ack |=> tx_req && $stable(tx_prop))
      else $error("tx request or proposal changed before ack");
   AST_RX_ACK_NEXT: assert property (s_tx_take |-> ##1 rx_ack)
      else $error("rx ack did not follow tx request");
   AST_TX_CLOSE: assert property (
      s_tx_done |=> !tx_req ##1 !rx_ack)
      else $error("tx handshake did not close in order");
   AST_RX_CLOSE: assert property (
      rx_req && tx_ack |=> !rx_req ##1 !tx_ack)
      else $error("rx handshake did not close in order");
   AST_RX_REQ_HOLD: assert property (
      rx_req && !tx_ack |=> rx_req && $stable(rx_prop))
      else $error("rx request or proposal changed before ack");
   AST_ONE_LEADER: assert property (!(tx_req && rx_req))
      else $error("both ends requesting at once");
   AST_TX_LEADS: assert property (
      s_tx_take |-> !$past(tx_auto && !rx_auto))
      else $error("tx led while rx was the manual end");
   AST_RX_LEADS: assert property (
      $rose(rx_req) |-> $past(tx_auto && !rx_auto))
      else $error("rx led without being the manual end");
   AST_AUTO_PROP: assert property (
      s_tx_take ##0 $past(tx_auto && rx_auto) |-> tx_prop ==
      ($past(tx_video_ok) ? link_mode_pkg::MODE_FULL_VIDEO :
       link_mode_pkg::MODE_SERIAL_NET))
      else $error("wrong proposal with both ends automatic");
   AST_SO_PROP: assert property (
      s_tx_take ##0 $past(any_so) |->
      tx_prop == link_mode_pkg::MODE_SERIAL_ONLY)
      else $error("serial only selection not proposed");
endmodule : link_mode_sva

// ---- verif/test_link_mode_resolver.sv ----
// Bench driving both variants through every pair of selections.
module test_link_mode_resolver;
   timeunit 1ns;
   timeprecision 1ps;
   // Expected modes, one nibble per tx/rx pair in encoding order.
   localparam logic [99:0] TF = 100'h11234_11234_22234_33333_44434;
   localparam logic [99:0] TB = 100'h11131_11131_33333_33333_33333;
   logic                 core_clk = 1'b0;
   logic                 rst_n    = 1'b0;
   link_mode_pkg::mode_t sel_tx   = link_mode_pkg::MODE_AUTO;
   link_mode_pkg::mode_t sel_rx   = link_mode_pkg::MODE_AUTO;
   logic                 vid      = 1'b1;
   link_mode_pkg::mode_t m[4];
   logic [15:0]          div[4];
   wire logic [3:0]      ven, nen, sen, busy;
   int                   num_errors = 0;
   int                   n_tests    = 0;
   twisted_pair_link_if lk[2] ();
   always #4 core_clk = ~core_clk;
   for (genvar g = 0; g < 2; g++) begin : g_var
      link_mode_tx #(.BASIC(g == 1)) i_link_mode_tx (.CORE_CLK(core_clk),
         .RST_N(rst_n), .LINK(lk[g]), .SEL_MODE(sel_tx), .VIDEO_VALID(vid),
         .MODE(m[2*g]), .VIDEO_EN(ven[2*g]), .NET_EN(nen[2*g]),
         .SERIAL_EN(sen[2*g]), .BAUD_DIV(div[2*g]), .BUSY(busy[2*g]));
      link_mode_rx #(.BASIC(g == 1)) i_link_mode_rx (.CORE_CLK(core_clk),
         .RST_N(rst_n), .LINK(lk[g]), .SEL_MODE(sel_rx),
         .MODE(m[2*g+1]), .VIDEO_EN(ven[2*g+1]), .NET_EN(nen[2*g+1]),
         .SERIAL_EN(sen[2*g+1]), .BAUD_DIV(div[2*g+1]), .BUSY(busy[2*g+1]));
   end
   link_mode_sva i_link_mode_sva (.CORE_CLK(core_clk), .RST_N(rst_n),
      .tx_sel(lk[0].tx_sel), .tx_video_ok(lk[0].tx_video_ok),
      .tx_req(lk[0].tx_req), .tx_prop(lk[0].tx_prop),
      .tx_ack(lk[0].tx_ack), .rx_sel(lk[0].rx_sel),
      .rx_req(lk[0].rx_req), .rx_prop(lk[0].rx_prop),
      .rx_ack(lk[0].rx_ack));
   task automatic check(input string nm, input logic [15:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic final_report();
      $display("mismatches %0d checks %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : final_report
   task automatic apply(input link_mode_pkg::mode_t t, r, input logic v,
                        input logic [3:0] ef, eb);
      logic [3:0] e;
      @(posedge core_clk);
      sel_tx <= t;
      sel_rx <= r;
      vid    <= v;
      // Wait out a whole negotiation first, so a mode that merely stays
      // where it was is not accepted before the ends have reacted.
      repeat (8) @(posedge core_clk);
      #1;
      for (int i = 0; i < 40 && !({m[0], m[1]} === {ef[2:0], ef[2:0]} &&
           {m[2], m[3]} === {eb[2:0], eb[2:0]} && busy === 4'h0); i++) begin
         @(posedge core_clk);
         #1;
      end
      for (int k = 0; k < 4; k++) begin
         e = (k < 2) ? ef : eb;
         check("mode", 16'(m[k]), 16'(e));
         check("video_en", 16'(ven[k]), 16'(e inside {4'h1, 4'h2}));
         check("net_en", 16'(nen[k]), 16'(e != 4'h3));
         check("serial_en", 16'(sen[k]), 16'h0001);
         check("baud_div", div[k], 16'h32dc);
      end
      check("busy", 16'(busy), 16'h0000);
   endtask : apply
   initial begin
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      for (int t = 0; t < 5; t++) begin
         for (int r = 0; r < 5; r++) begin
            apply(link_mode_pkg::mode_t'(t), link_mode_pkg::mode_t'(r), 1'b1,
                  TF[(24-5*t-r)*4 +: 4], TB[(24-5*t-r)*4 +: 4]);
         end
      end
      apply(link_mode_pkg::MODE_AUTO, link_mode_pkg::MODE_AUTO, 1'b1,
            4'h1, 4'h1);
      apply(link_mode_pkg::MODE_AUTO, link_mode_pkg::MODE_AUTO, 1'b0,
            4'h4, 4'h3);
      apply(link_mode_pkg::MODE_AUTO, link_mode_pkg::MODE_FULL_VIDEO, 1'b0,
            4'h1, 4'h1);
      @(posedge core_clk);
      rst_n <= 1'b0;
      @(posedge core_clk);
      #1;
      for (int k = 0; k < 4; k++) begin
         check("reset_mode", 16'(m[k]), 16'h0003);
         check("reset_video", 16'(ven[k]), 16'h0000);
         check("reset_net", 16'(nen[k]), 16'h0000);
      end
      check("reset_busy", 16'(busy), 16'h0000);
      @(posedge core_clk);
      rst_n <= 1'b1;
      apply(link_mode_pkg::MODE_SERIAL_NET, link_mode_pkg::MODE_EXT_REACH,
            1'b1, 4'h4, 4'h3);
      final_report();
   end
   // About 30 settings of at most 50 cycles each, with ample margin.
   initial begin
      #30000;
      num_errors++;
      final_report();
   end
endmodule : test_link_mode_resolver
